// ==== include/acc_pkg.sv ====
package acc_pkg;
	// ==========
	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_STATUS = 8'h08;
	localparam logic [7:0] IDX_CMD = 8'h0C;
	localparam logic [7:0] IDX_EVCLR = 8'h10;
	localparam logic [7:0] IDX_EVVIEW = 8'h12;
	localparam logic [7:0] IDX_TRAPST = 8'h14;
	localparam logic [7:0] IDX_TRAPEN = 8'h18;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========
	// Codec status register fields.
	localparam int ST_INTEN = 23;
	localparam int ST_SHPIN = 21;
	localparam int ST_BM5 = 20;
	localparam int ST_BM4 = 19;
	localparam int ST_NEW = 17;
	localparam int ST_VALID = 16;
	localparam logic [31:0] ST_WMASK = 32'h00B8_0000;
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	// ==========
	// Codec command register fields.
	localparam int CMD_ADDR_LSB = 24;
	localparam int CMD_SEL_LSB = 22;
	localparam int CMD_VALID = 16;
	localparam logic [31:0] CMD_WMASK = 32'hFFC0_FFFF;
	localparam logic [31:0] CMD_RST = 32'h0000_0000;
	localparam logic [1:0] CODEC_SEC = 2'h1;
	// ==========
	// Trap enable and trap status fields.
	localparam int EN_SB = 0;
	localparam int EN_FM = 1;
	localparam int EN_SBBASE_LSB = 2;
	localparam int EN_FASTRD = 4;
	localparam int EN_FASTWR = 11;
	localparam int EN_FRDATA_LSB = 24;
	localparam logic [31:0] EN_WMASK = 32'hFF00_081F;
	localparam logic [31:0] TRAPEN_RST = 32'h0000_0000;
	localparam int TS_ADDR_LSB = 0;
	localparam int TS_TRAP = 12;
	localparam int TS_PEND = 13;
	localparam int TS_WR = 14;
	localparam int TS_A1 = 15;
	localparam int TS_DATA_LSB = 16;
	localparam int TS_FW_LSB = 24;
	localparam logic [31:0] TRAPST_RST = 32'h0000_0000;
	localparam int EV_TRAP = 0;
	localparam logic [15:0] EV_RST = 16'h0000;
	// ==========
	// Legacy port map.
	localparam logic [9:0] FM_BASE = 10'h388;
	localparam logic [9:0] SB_BASE0 = 10'h220;
	localparam logic [9:0] SB_STEP = 10'h020;
	// ==========
	// Serial frame layout.
	localparam logic [3:0] SLOT_TAG = 4'h0;
	localparam logic [3:0] SLOT_ADDR = 4'h1;
	localparam logic [3:0] SLOT_DATA = 4'h2;
	localparam logic [3:0] SLOT_IRQ = 4'hC;
	localparam logic [3:0] SLOT_IDLE = 4'hD;
	localparam logic [3:0] SLOT6 = 4'h6;
	localparam logic [3:0] SLOT11 = 4'hB;
	localparam logic [4:0] TAG_MSB = 5'h0F;
	localparam logic [4:0] SLOT_MSB = 5'h13;
	localparam int TAG_FRAME = 15;
	localparam int TAG_S1 = 14;
	localparam int TAG_S2 = 13;
	localparam int FLD_MSB = 19;
	localparam int FLD_ADDR_LSB = 12;
	localparam int FLD_DATA_LSB = 4;
	localparam int LN_CLK = 0;
endpackage

// ==== hw/acc_link_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module acc_link_sync
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic bitClkPin,
	input wire logic syncPin,
	input wire logic dataPin,
	input wire logic data2Pin,
	output logic bitRise,
	output logic bitFall,
	output logic syncLvl,
	output logic dataLvl,
	output logic data2Lvl
);
	logic [3:0] raw;
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s3_r;
	logic [3:0] lvl_r;
	logic [3:0] lvl_nxt;

	assign raw = {data2Pin, dataPin, syncPin, bitClkPin};
	// A lane moves only once stages two and three agree, so a one-cycle glitch is ignored.
	assign lvl_nxt = (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
	assign syncLvl = lvl_r[LN_CLK + 1];
	assign dataLvl = lvl_r[LN_CLK + 2];
	assign data2Lvl = lvl_r[LN_CLK + 3];

	always_ff @(posedge clk) begin
		if (srst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
			bitRise <= 1'b0;
			bitFall <= 1'b0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
			bitRise <= lvl_nxt[LN_CLK] & ~lvl_r[LN_CLK];
			bitFall <= ~lvl_nxt[LN_CLK] & lvl_r[LN_CLK];
		end
	end
endmodule
`default_nettype wire

// ==== hw/acc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] Status bit 21 picks shared pin function.
// [RULE2] Status bit 20 picks bus master 5 slot.
// [RULE3] Status bit 19: bus master 4 slot 6/11.
// [RULE4] Status bit 17 flags an unseen status word.
// [RULE5] Status bit 16 flags a valid status word.
// [RULE6] Status low half holds slot 2 bits 19:4.
// [RULE7] Command top byte goes out in slot 1.
// [RULE8] Command bits 23:22 select the target codec.
// [RULE9] Command valid set on load until sent.
// [RULE10] Command data goes out in slot 2.
// [RULE11] Trapped host access raises the management interrupt.
// [RULE12] Event status readable at clearing and viewing offsets.
// [RULE13] Reading the clearing offset clears event bits.
// [RULE14] Trap status shows trap and fast write capture.
// [RULE15] Trap enable selects ranges and fast paths.
// [RULE16] Fast read answers status ports without interrupt.
// [RULE17] Fast read covers 388-38B and base ports.
// [RULE18] No read trapping unless mapping enabled.
// [RULE19] Fast write makes index/data pairs interrupt once.
// [RULE20] First pair write captures data and A1 quietly.
// [RULE21] Second pair write traps like ordinary access.
// [RULE22] Fast write covers 388/38A/38B and base ports.
// [RULE23] Status updates on each frame with valid slot.
// [RULE24] Status bit 23 gates codec serial interrupt.
// [RULE25] Codec drives bit clock and frame timing.
// [RULE26] Command valid clears in its transmit frame.
// [RULE27] New flag sets on capture, clears on read.
// [RULE28] Interrupt holds while any event bit set.
module acc_top
	import acc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic bitClk,
	input wire logic frameSync,
	input wire logic serialIn,
	input wire logic secondSerialInput,
	output logic serialOut,
	output logic sharedGeneralPinIsData,
	output logic bm5RxSlotSel,
	output logic [3:0] bm4TxSlot,
	input wire logic ioValid,
	input wire logic ioWrite,
	input wire logic [9:0] ioAddr,
	input wire logic [7:0] ioWdata,
	output logic fastReadHit,
	output logic [7:0] fastReadData,
	input wire logic [5:0] bmEvent,
	output logic systemMgmtInterruptOut
);
	function automatic logic [7:0] idxOf(input logic [ADDR_W-1:0] a);
		return 8'(a[ADDR_W-1:2]);
	endfunction

	function automatic logic isMapped(input logic [7:0] i);
		return i inside {IDX_STATUS, IDX_CMD, IDX_EVCLR, IDX_EVVIEW, IDX_TRAPST, IDX_TRAPEN};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s,
			input logic [31:0] wm);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wm;
		return (o & ~m) | (n & m);
	endfunction

	function automatic logic txBit(input logic [3:0] s, input logic [4:0] b, input logic p, input logic [31:0] c);
		logic [15:0] tag;
		logic [19:0] w;
		tag = '0;
		w = '0;
		tag[TAG_FRAME] = p;
		tag[TAG_S1] = p;
		tag[TAG_S2] = p;
		tag[1:0] = c[CMD_SEL_LSB +: 2];
		if (s == SLOT_ADDR) begin
			w[FLD_MSB:FLD_ADDR_LSB] = c[CMD_ADDR_LSB +: 8];
		end
		if (s == SLOT_DATA) begin
			w[FLD_MSB:FLD_DATA_LSB] = c[15:0];
		end
		return (s == SLOT_TAG) ? tag[b[3:0]] : (p & w[b]);
	endfunction

	function automatic logic isSb(input logic [9:0] a, input logic [1:0] sel);
		logic [9:0] base;
		base = SB_BASE0 + 10'(SB_STEP * sel);
		return a[9:4] == base[9:4];
	endfunction

	// ==========
	// Link sampling and frame position
	logic bitRise, bitFall, syncLvl, rxA, rxB;
	logic [3:0] slot_r, slot_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic syncPrev_r, txPend_r, txPend_nxt, frameStart, cmdSent;
	logic [19:0] rx_r, rxWord;
	logic rxS2_r, rxBit, slotEnd, statusCap, codecIrqEv;
	logic [7:0] rxAddr_r;
	logic [31:0] status_r, cmd_r, trapSt_r, trapEn_r;
	logic [15:0] ev_r, evSet;

	acc_link_sync uSync (
		.clk(clk),
		.srst(srst),
		.bitClkPin(bitClk),
		.syncPin(frameSync),
		.dataPin(serialIn),
		.data2Pin(secondSerialInput),
		.bitRise(bitRise),
		.bitFall(bitFall),
		.syncLvl(syncLvl),
		.dataLvl(rxA),
		.data2Lvl(rxB)
	);

	// The codec owns bit clock and frame sync; frames start only on its sync edge.
	assign frameStart = syncLvl && !syncPrev_r; // [RULE25]
	assign txPend_nxt = frameStart ? cmd_r[CMD_VALID] : txPend_r;
	assign cmdSent = bitRise && txPend_r && slot_r == SLOT_DATA && bit_r == '0; // [RULE26]

	always_comb begin
		slot_nxt = slot_r;
		bit_nxt = bit_r;
		if (frameStart) begin
			slot_nxt = SLOT_TAG;
			bit_nxt = TAG_MSB;
		end else if (slot_r != SLOT_IDLE) begin
			if (bit_r != '0) begin
				bit_nxt = bit_r - 5'd1;
			end else begin
				slot_nxt = slot_r + 4'd1;
				bit_nxt = SLOT_MSB;
			end
		end
	end

	// Outgoing bits change on the bit clock rise; the codec samples just before the next rise.
	always_ff @(posedge clk) begin
		if (srst) begin
			slot_r <= SLOT_IDLE;
			bit_r <= '0;
			syncPrev_r <= 1'b0;
			txPend_r <= 1'b0;
			serialOut <= 1'b0;
		end else if (bitRise) begin
			slot_r <= slot_nxt;
			bit_r <= bit_nxt;
			syncPrev_r <= syncLvl;
			serialOut <= txBit(slot_nxt, bit_nxt, txPend_nxt, cmd_r); // [RULE7] [RULE8] [RULE10]
			txPend_r <= cmdSent ? 1'b0 : txPend_nxt;
		end
	end

	// ==========
	// Incoming frame
	assign rxBit = (status_r[ST_SHPIN] && cmd_r[CMD_SEL_LSB +: 2] == CODEC_SEC) ? rxB : rxA; // [RULE1]
	assign rxWord = {rx_r[18:0], rxBit};
	assign slotEnd = bitFall && bit_r == '0;
	assign statusCap = slotEnd && slot_r == SLOT_DATA && rxS2_r; // [RULE23]
	assign codecIrqEv = slotEnd && slot_r == SLOT_IRQ && rxWord[0] && status_r[ST_INTEN]; // [RULE24]

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_r <= '0;
			rxS2_r <= 1'b0;
			rxAddr_r <= '0;
		end else if (bitFall) begin
			rx_r <= rxWord;
			if (slotEnd && slot_r == SLOT_TAG) begin
				rxS2_r <= rxWord[TAG_FRAME] & rxWord[TAG_S2];
			end
			if (slotEnd && slot_r == SLOT_ADDR) begin
				rxAddr_r <= rxWord[FLD_MSB:FLD_ADDR_LSB];
			end
		end
	end

	// ==========
	// Register bus slave
	logic [ADDR_W-1:0] awAddr_r;
	logic [31:0] wData_r, rdMux;
	logic [3:0] wStrb_r;
	logic doWrite, rdTake, evClr;
	logic [7:0] wIdx, rIdx;

	// A write completes once both address and data are held and no response is pending.
	assign doWrite = !awready && !wready && !bvalid;
	assign rdTake = arvalid && arready;
	assign wIdx = idxOf(awAddr_r);
	assign rIdx = idxOf(araddr);

	always_comb begin
		rdMux = '0;
		case (rIdx)
			IDX_STATUS: rdMux = status_r;
			IDX_CMD: rdMux = cmd_r;
			IDX_EVCLR, IDX_EVVIEW: rdMux = {16'h0000, ev_r}; // [RULE12]
			IDX_TRAPST: rdMux = trapSt_r;
			IDX_TRAPEN: rdMux = trapEn_r;
			default: rdMux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OK;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
		end else begin
			if (awvalid && awready) begin
				awAddr_r <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_r <= wdata;
				wStrb_r <= wstrb;
				wready <= 1'b0;
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp <= isMapped(wIdx) ? RESP_OK : RESP_SLVERR;
				awready <= 1'b1;
				wready <= 1'b1;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OK;
		end else if (rdTake) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rdMux;
			rresp <= isMapped(rIdx) ? RESP_OK : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ==========
	// Codec status and command registers
	always_ff @(posedge clk) begin
		if (srst) begin
			status_r <= STATUS_RST;
		end else begin
			if (doWrite && wIdx == IDX_STATUS) begin
				status_r <= merge(status_r, wData_r, wStrb_r, ST_WMASK); // [RULE1] [RULE2] [RULE3] [RULE24]
			end
			if (rdTake && rIdx == IDX_STATUS) begin
				status_r[ST_NEW] <= 1'b0; // [RULE27]
			end
			if (statusCap) begin
				status_r[CMD_ADDR_LSB +: 8] <= rxAddr_r;
				status_r[15:0] <= rxWord[FLD_MSB:FLD_DATA_LSB]; // [RULE6]
				status_r[ST_NEW] <= 1'b1; // [RULE4] [RULE27]
				status_r[ST_VALID] <= 1'b1; // [RULE5]
			end
		end
	end

	// A command rewritten mid-frame goes out partly old and partly new; software waits for valid low.
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_r <= CMD_RST;
		end else begin
			if (cmdSent) begin
				cmd_r[CMD_VALID] <= 1'b0; // [RULE26]
			end
			if (doWrite && wIdx == IDX_CMD) begin
				cmd_r <= merge(cmd_r, wData_r, wStrb_r, CMD_WMASK);
				cmd_r[CMD_VALID] <= 1'b1; // [RULE9]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sharedGeneralPinIsData <= 1'b0;
			bm5RxSlotSel <= 1'b0;
			bm4TxSlot <= SLOT6;
		end else begin
			sharedGeneralPinIsData <= status_r[ST_SHPIN]; // [RULE1]
			bm5RxSlotSel <= status_r[ST_BM5]; // [RULE2]
			bm4TxSlot <= status_r[ST_BM4] ? SLOT11 : SLOT6; // [RULE3]
		end
	end

	// ==========
	// Legacy port traps
	logic fmHit, sbHit, mapHit, fastRd, fastWrFirst, trapEv;
	logic [3:0] lo;

	assign lo = ioAddr[3:0];
	assign fmHit = trapEn_r[EN_FM] && ioAddr[9:2] == FM_BASE[9:2];
	assign sbHit = trapEn_r[EN_SB] && isSb(ioAddr, trapEn_r[EN_SBBASE_LSB +: 2]);
	assign mapHit = ioValid && (fmHit || sbHit); // [RULE15] [RULE18]
	assign fastRd = mapHit && !ioWrite && trapEn_r[EN_FASTRD]
		&& (fmHit || lo inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9}); // [RULE16] [RULE17]
	assign fastWrFirst = mapHit && ioWrite && trapEn_r[EN_FASTWR] && !trapSt_r[TS_PEND]
		&& (fmHit ? lo[1:0] != 2'h1 : lo inside {4'h0, 4'h2, 4'h8}); // [RULE19] [RULE22]
	assign trapEv = mapHit && !fastRd && !fastWrFirst; // [RULE11] [RULE21]

	always_ff @(posedge clk) begin
		if (srst) begin
			trapEn_r <= TRAPEN_RST;
		end else if (doWrite && wIdx == IDX_TRAPEN) begin
			trapEn_r <= merge(trapEn_r, wData_r, wStrb_r, EN_WMASK); // [RULE15]
		end
	end

	// Trap-taken flag is cleared by reading trap status; a new trap or a first fast write in that cycle wins and the clear is lost.
	always_ff @(posedge clk) begin
		if (srst) begin
			trapSt_r <= TRAPST_RST;
		end else if (fastWrFirst) begin
			trapSt_r[TS_FW_LSB +: 8] <= ioWdata; // [RULE20]
			trapSt_r[TS_A1] <= ioAddr[1]; // [RULE20]
			trapSt_r[TS_PEND] <= 1'b1;
		end else if (trapEv) begin
			trapSt_r[TS_DATA_LSB +: 8] <= ioWdata; // [RULE14] [RULE21]
			trapSt_r[TS_ADDR_LSB +: 10] <= ioAddr;
			trapSt_r[TS_WR] <= ioWrite;
			trapSt_r[TS_TRAP] <= 1'b1;
			trapSt_r[TS_PEND] <= 1'b0;
		end else if (rdTake && rIdx == IDX_TRAPST) begin
			trapSt_r[TS_TRAP] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			fastReadHit <= 1'b0;
			fastReadData <= '0;
		end else begin
			fastReadHit <= fastRd; // [RULE16]
			fastReadData <= trapEn_r[EN_FRDATA_LSB +: 8];
		end
	end

	// ==========
	// Event status and interrupt
	assign evSet = {8'h00, bmEvent, codecIrqEv, trapEv};
	assign evClr = rdTake && rIdx == IDX_EVCLR;

	always_ff @(posedge clk) begin
		if (srst) begin
			ev_r <= EV_RST;
			systemMgmtInterruptOut <= 1'b0;
		end else begin
			ev_r <= (evClr ? EV_RST : ev_r) | evSet; // [RULE13]
			systemMgmtInterruptOut <= ev_r != EV_RST; // [RULE11] [RULE28]
		end
	end

	// ==========
	// Checks
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (srst);

	cmd_load_a: assert property (doWrite && wIdx == IDX_CMD |=> cmd_r[CMD_VALID]) // [RULE9]
		else $error("command valid not set after load");
	cmd_sent_a: assert property (cmdSent && !(doWrite && wIdx == IDX_CMD) |=> !cmd_r[CMD_VALID]) // [RULE26]
		else $error("command valid still set after slot 2");
	smi_hold_a: assert property (ev_r != EV_RST |=> systemMgmtInterruptOut) // [RULE28]
		else $error("interrupt low while event pending");
	smi_drop_a: assert property (ev_r == EV_RST |=> !systemMgmtInterruptOut) // [RULE28]
		else $error("interrupt high with no event");
	trap_smi_a: assert property (trapEv |-> ##2 systemMgmtInterruptOut) // [RULE11]
		else $error("trap did not raise interrupt");
	fast_read_a: assert property (fastRd |=> fastReadHit ##0 !$rose(ev_r[EV_TRAP])) // [RULE16]
		else $error("fast read not answered or trapped");
	fast_map_a: assert property (ioValid && !mapHit |=> !fastReadHit) // [RULE18]
		else $error("fast read without port mapping");
	fw_first_a: assert property (fastWrFirst |=> trapSt_r[TS_PEND] // [RULE20]
		&& trapSt_r[TS_A1] == $past(ioAddr[1]) && trapSt_r[TS_FW_LSB +: 8] == $past(ioWdata))
		else $error("first fast write not captured");
	fw_second_a: assert property (mapHit && ioWrite && trapEn_r[EN_FASTWR] && trapSt_r[TS_PEND] // [RULE21]
		|=> ev_r[EV_TRAP] && !trapSt_r[TS_PEND])
		else $error("second fast write did not trap");
	ev_clear_a: assert property (evClr && evSet == EV_RST |=> ev_r == EV_RST) // [RULE13]
		else $error("clearing read left event bits");
	ev_view_a: assert property (rdTake && rIdx == IDX_EVVIEW |=> (ev_r & $past(ev_r)) == $past(ev_r)) // [RULE12]
		else $error("viewing read cleared event bits");
	st_capture_a: assert property (statusCap |=> status_r[ST_NEW] && status_r[ST_VALID] // [RULE23]
		&& status_r[15:0] == $past(rxWord[FLD_MSB:FLD_DATA_LSB]))
		else $error("status word not captured");
	st_seen_a: assert property (rdTake && rIdx == IDX_STATUS && !statusCap |=> !status_r[ST_NEW]) // [RULE27]
		else $error("new flag survived status read");
	bm4_slot_a: assert property (status_r[ST_BM4] |=> bm4TxSlot == SLOT11) // [RULE3]
		else $error("bus master 4 slot wrong");

	status_seen_c: cover property (statusCap);
	cmd_sent_c: cover property (cmdSent);
	fw_pair_c: cover property (fastWrFirst ##[1:50] trapEv);
	fast_read_c: cover property (fastRd);
endmodule
`default_nettype wire

// ==== dv/acc_codec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Codec partner: it owns the link clock and the frame timing.
module acc_codec_model (
	input wire logic serialOut,
	input wire logic [7:0] stAddr,
	input wire logic [15:0] stData,
	input wire logic irq,
	output logic bitClk,
	output logic frameSync,
	output logic serialIn,
	output logic secondSerialInput,
	output logic [255:0] seen
);
	logic [255:0] v;
	initial begin
		bitClk = 1'b0;
		frameSync = 1'b0;
		serialIn = 1'b0;
		secondSerialInput = 1'b1;
		seen = '0;
	end
	// The clock stands still between frames, so the device cannot lean on a free-running clock.
	// The second line differs from the first only in the slot 2 status word.
	task automatic frame();
		v = {16'hE000, stAddr, 12'h000, stData, 4'h0, 180'h0, 19'h0, irq};
		frameSync = 1'b1;
		#100;
		for (int i = 255; i >= 0; i--) begin
			frameSync = (i > 239);
			serialIn = v[i];
			secondSerialInput = (i > 203 && i < 220) ? ~v[i] : v[i];
			bitClk = 1'b1;
			#100;
			bitClk = 1'b0;
			// Sampled late in the bit because the device answers some clocks after the rise.
			#95;
			seen[i] = serialOut;
			#5;
		end
		serialIn = ~serialIn;
		secondSerialInput = ~secondSerialInput;
	endtask
endmodule
`default_nettype wire

// ==== dv/acc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module acc_top_test
	import acc_pkg::*;
;
	localparam logic [7:0] A_ST = 8'(IDX_STATUS << 2);
	localparam logic [7:0] A_CMD = 8'(IDX_CMD << 2);
	localparam logic [7:0] A_CLR = 8'(IDX_EVCLR << 2);
	localparam logic [7:0] A_EV = 8'(IDX_EVVIEW << 2);
	localparam logic [7:0] A_TS = 8'(IDX_TRAPST << 2);
	localparam logic [7:0] A_EN = 8'(IDX_TRAPEN << 2);
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic ioValid = 1'b0, ioWrite = 1'b0;
	logic [9:0] ioAddr = 10'h000;
	logic [7:0] ioWdata = 8'h00;
	logic [5:0] bmEvent = 6'h00;
	logic [7:0] stAddr = 8'h00;
	logic [15:0] stData = 16'h0000;
	logic irq = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, serialOut, sharedGeneralPinIsData, bm5RxSlotSel;
	logic fastReadHit, systemMgmtInterruptOut, bitClk, frameSync, serialIn, secondSerialInput, hit;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [3:0] bm4TxSlot;
	logic [7:0] fastReadData;
	logic [255:0] seen;
	logic [9:0] frd [10] = '{10'h388, 10'h389, 10'h38A, 10'h38B, 10'h220, 10'h221, 10'h222, 10'h223, 10'h228, 10'h229};
	logic [9:0] fwr [6] = '{10'h388, 10'h38A, 10'h38B, 10'h220, 10'h222, 10'h228};
	int n_errors = 0;
	int cmp_count = 0;

	always #12.5 clk = ~clk;

	acc_top #(.ADDR_W(8)) u_dut (
		.clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .bitClk(bitClk), .frameSync(frameSync), .serialIn(serialIn),
		.secondSerialInput(secondSerialInput), .serialOut(serialOut), .sharedGeneralPinIsData(sharedGeneralPinIsData),
		.bm5RxSlotSel(bm5RxSlotSel), .bm4TxSlot(bm4TxSlot), .ioValid(ioValid), .ioWrite(ioWrite), .ioAddr(ioAddr),
		.ioWdata(ioWdata), .fastReadHit(fastReadHit), .fastReadData(fastReadData), .bmEvent(bmEvent),
		.systemMgmtInterruptOut(systemMgmtInterruptOut)
	);

	acc_codec_model u_codec (
		.serialOut(serialOut), .stAddr(stAddr), .stData(stData), .irq(irq), .bitClk(bitClk),
		.frameSync(frameSync), .serialIn(serialIn), .secondSerialInput(secondSerialInput), .seen(seen)
	);

	// ==========
	// Bus and port access tasks.
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OK);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (awready) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (wready) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk(bresp, er);
		// Registered side outputs follow the register one edge after the response.
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		// A clearing read reaches the interrupt output one edge after the handshake.
		@(posedge clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OK);
		rd(a);
		chk({r, d}, {er, e});
	endtask

	// The pulse output is caught just after the edge that launches it; the wait leaves time for the interrupt.
	task automatic io(input logic w, input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		ioValid <= 1'b1;
		ioWrite <= w;
		ioAddr <= a;
		ioWdata <= v;
		@(posedge clk);
		ioValid <= 1'b0;
		#1;
		hit = fastReadHit;
		repeat (4) @(posedge clk);
	endtask

	task automatic results();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Two frames take about 4100 clocks; the limit leaves ample room.
	initial begin
		#1000000;
		n_errors++;
		results();
	end

	// ==========
	// Test sequence.
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rdc(A_ST, STATUS_RST);
		rdc(A_CMD, CMD_RST);
		rdc(A_EN, TRAPEN_RST);
		rdc(A_TS, TRAPST_RST);
		rdc(A_EV, {16'h0000, EV_RST});
		rdc(8'h04, 32'h0000_0000, RESP_SLVERR);
		wr(8'h04, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(A_ST, 32'hFFFF_FFFF);
		rdc(A_ST, ST_WMASK);
		chk(sharedGeneralPinIsData, 1'b1);
		chk(bm5RxSlotSel, 1'b1);
		chk(bm4TxSlot, SLOT11);
		wr(A_CMD, 32'hA540_1234);
		rdc(A_CMD, 32'hA541_1234);
		stAddr = 8'h3C;
		stData = 16'hBEEF;
		u_codec.frame();
		repeat (8) @(posedge clk);
		chk(seen[239:232], 8'hA5);
		chk(seen[219:204], 16'h1234);
		chk(seen[255:240], 16'hE001);
		rdc(A_CMD, 32'hA540_1234);
		rdc(A_ST, 32'h3CBB_4110);
		rdc(A_ST, 32'h3CB9_4110);
		rdc(A_EV, 32'h0000_0000);
		wr(A_ST, 32'h0080_0000);
		chk(bm4TxSlot, SLOT6);
		chk(sharedGeneralPinIsData, 1'b0);
		chk(bm5RxSlotSel, 1'b0);
		stData = 16'h1357;
		irq = 1'b1;
		u_codec.frame();
		repeat (8) @(posedge clk);
		rdc(A_ST, 32'h3C83_1357);
		rdc(A_EV, 32'h0000_0002);
		chk(systemMgmtInterruptOut, 1'b1);
		rdc(A_CLR, 32'h0000_0002);
		rdc(A_EV, 32'h0000_0000);
		chk(systemMgmtInterruptOut, 1'b0);
		wr(A_EN, 32'h0000_0002);
		io(1'b0, 10'h388, 8'h00);
		chk(systemMgmtInterruptOut, 1'b1);
		rdc(A_TS, 32'h0000_1388);
		rdc(A_TS, 32'h0000_0388);
		rdc(A_EV, 32'h0000_0001);
		rdc(A_CLR, 32'h0000_0001);
		chk(systemMgmtInterruptOut, 1'b0);
		wr(A_EN, 32'h0000_0010);
		io(1'b0, 10'h388, 8'h00);
		chk(systemMgmtInterruptOut, 1'b0);
		rdc(A_TS, 32'h0000_0388);
		wr(A_EN, 32'h7700_0013);
		foreach (frd[i]) begin
			io(1'b0, frd[i], 8'h00);
			chk(hit, 1'b1);
			chk(fastReadData, 8'h77);
		end
		chk(systemMgmtInterruptOut, 1'b0);
		io(1'b0, 10'h224, 8'h00);
		chk(hit, 1'b0);
		rdc(A_TS, 32'h0000_1224);
		rdc(A_CLR, 32'h0000_0001);
		wr(A_EN, 32'h0000_0005);
		io(1'b0, 10'h243, 8'h00);
		rdc(A_TS, 32'h0000_1243);
		rdc(A_CLR, 32'h0000_0001);
		wr(A_EN, 32'h0000_0803);
		foreach (fwr[i]) begin
			io(1'b1, fwr[i], 8'h40 + 8'(i));
			chk(systemMgmtInterruptOut, 1'b0);
			io(1'b1, 10'h389, 8'h5A);
			chk(systemMgmtInterruptOut, 1'b1);
			rdc(A_TS, {8'h40 + 8'(i), 8'h5A, fwr[i][1], 5'b10100, 10'h389});
			rdc(A_CLR, 32'h0000_0001);
		end
		bmEvent <= 6'h21;
		@(posedge clk);
		bmEvent <= 6'h00;
		repeat (4) @(posedge clk);
		chk(systemMgmtInterruptOut, 1'b1);
		rdc(A_CLR, 32'h0000_0084);
		chk(systemMgmtInterruptOut, 1'b0);
		results();
	end
endmodule
`default_nettype wire
